// ### logic/spdp_pkg.sv
`default_nettype none

package spdp_pkg;

    // ****************************************************
    // Geometry
    // ****************************************************
    localparam int SPDP_ADDR_W     = 16;
    localparam int SPDP_DATA_W     = 18;
    localparam int SPDP_LANE_W     = 9;
    localparam int SPDP_LANES      = 2;
    localparam int SPDP_DEPTH      = 65536;
    localparam int SPDP_PORTS      = 2;

    // ****************************************************
    // Timing counts, in clock cycles
    // ****************************************************
    localparam int       SPDP_READ_LAT    = 2;
    localparam logic [1:0] SPDP_WAKE_CYCLES = 2'h2;
    localparam logic [2:0] SPDP_RSP_TAP     = 3'h4;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [15:0] SPDP_ADDR_RST = 16'h0000;
    localparam logic [17:0] SPDP_DATA_RST = 18'h0_0000;

    // ****************************************************
    // Master counter operations
    // ****************************************************
    localparam logic [1:0] SPDP_OP_LOAD    = 2'h0;
    localparam logic [1:0] SPDP_OP_ADVANCE = 2'h1;
    localparam logic [1:0] SPDP_OP_HOLD    = 2'h2;

    // ****************************************************
    // Pins driven by the master into one port
    // ****************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic        read;
        logic        first_select_n;
        logic        second_select;
        logic        address_load_strobe_n;
        logic        count_advance_n;
        logic        count_clear_n;
        logic        upper_lane_enable_n;
        logic        lower_lane_enable_n;
        logic        out_enable_n;
    } spdp_ctl_t;

    // Idle, deselected pin levels
    localparam spdp_ctl_t SPDP_CTL_RST = '{
        addr: 16'h0000, read: 1'b1, first_select_n: 1'b1, second_select: 1'b0,
        address_load_strobe_n: 1'b0, count_advance_n: 1'b1, count_clear_n: 1'b1,
        upper_lane_enable_n: 1'b1, lower_lane_enable_n: 1'b1, out_enable_n: 1'b1};

endpackage : spdp_pkg

`default_nettype wire

// ### logic/spdp_if.sv
`timescale 1ns/10ps
`default_nettype none

interface spdp_if;
    import spdp_pkg::*;

    spdp_ctl_t   ctl;
    logic [17:0] mst_data;
    logic [1:0]  mst_data_oe;
    logic [17:0] dev_data;
    logic [1:0]  dev_data_oe;
    logic [17:0] bus;

    // ****************************************************
    // Shared data wire, per byte lane
    // ****************************************************
    assign bus[8:0]   = dev_data_oe[0] ? dev_data[8:0]   : (mst_data_oe[0] ? mst_data[8:0]   : 9'h000);
    assign bus[17:9]  = dev_data_oe[1] ? dev_data[17:9]  : (mst_data_oe[1] ? mst_data[17:9]  : 9'h000);

    modport dev (input ctl, input bus, output dev_data, output dev_data_oe);
    modport mst (output ctl, input bus, output mst_data, output mst_data_oe);

endinterface : spdp_if

`default_nettype wire

// ### logic/spdp_port_dev.sv
`timescale 1ns/10ps
`default_nettype none

module spdp_port_dev
    import spdp_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Left and right ports
    spdp_if.dev       port_a,
    spdp_if.dev       port_b
);

    // ****************************************************
    // Types
    // ****************************************************
    typedef struct packed {
        spdp_ctl_t   ctl;
        logic [17:0] wdata;
        logic [15:0] counter;
        logic        awake;
        logic [17:0] q;
        logic [1:0]  drive;
    } spdp_dev_port_t;

    typedef struct packed {
        spdp_dev_port_t [SPDP_PORTS-1:0] port;
    } spdp_dev_state_t;

    // ****************************************************
    // Decoding helpers
    // ****************************************************
    function automatic logic spdp_selected(input spdp_ctl_t c);
        spdp_selected = ~c.first_select_n & c.second_select;
    endfunction

    function automatic logic [15:0] spdp_int_addr(input spdp_ctl_t c, input logic [15:0] cnt);
        if (!c.count_clear_n) begin
            spdp_int_addr = SPDP_ADDR_RST;
        end else if (!c.address_load_strobe_n) begin
            spdp_int_addr = c.addr;
        end else if (!c.count_advance_n) begin
            spdp_int_addr = 16'(cnt + 16'h0001);
        end else begin
            spdp_int_addr = cnt;
        end
    endfunction

    // ****************************************************
    // Storage and port arrays
    // ****************************************************
    logic [17:0]     mem [SPDP_DEPTH];
    spdp_dev_state_t st_reg;
    spdp_dev_state_t st_next;
    spdp_ctl_t       ctl_in   [SPDP_PORTS];
    logic [17:0]     bus_in   [SPDP_PORTS];
    logic [15:0]     iaddr    [SPDP_PORTS];
    logic            sel_now  [SPDP_PORTS];
    logic [1:0]      wr_lane  [SPDP_PORTS];
    logic [1:0]      oe_gate  [SPDP_PORTS];

    assign ctl_in[0] = port_a.ctl;
    assign ctl_in[1] = port_b.ctl;
    assign bus_in[0] = port_a.bus;
    assign bus_in[1] = port_b.bus;

    // ****************************************************
    // Per-port decode from sampled inputs, except the unregistered output enable
    // ****************************************************
    genvar gp;
    generate
        for (gp = 0; gp < SPDP_PORTS; gp++) begin : g_dec
            // Only registered pins feed the access path
            assign sel_now[gp] = spdp_selected(st_reg.port[gp].ctl);
            assign iaddr[gp]   = spdp_int_addr(st_reg.port[gp].ctl, st_reg.port[gp].counter);
            // Lanes written only on a selected write cycle
            assign wr_lane[gp] = (sel_now[gp] && !st_reg.port[gp].ctl.read)
                               ? ~{st_reg.port[gp].ctl.upper_lane_enable_n,
                                   st_reg.port[gp].ctl.lower_lane_enable_n}
                               : 2'b00;
            // Output enable bypasses every register
            assign oe_gate[gp] = st_reg.port[gp].drive & {2{~ctl_in[gp].out_enable_n}};
        end
    endgenerate

    assign port_a.dev_data    = st_reg.port[0].q;
    assign port_a.dev_data_oe = oe_gate[0];
    assign port_b.dev_data    = st_reg.port[1].q;
    assign port_b.dev_data_oe = oe_gate[1];

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        st_next = st_reg;
        for (int p = 0; p < SPDP_PORTS; p++) begin
            // Input registers
            st_next.port[p].ctl   = ctl_in[p];
            st_next.port[p].wdata = bus_in[p];
            // Counter tracks the internal address; frozen in standby
            if (sel_now[p]) begin
                st_next.port[p].counter = iaddr[p];
            end
            // Drivers need two consecutive selected samples
            st_next.port[p].awake = sel_now[p];
            // Output state for next cycle from this cycle's sampled pins
            if (sel_now[p] && st_reg.port[p].awake && st_reg.port[p].ctl.read) begin
                st_next.port[p].drive = ~{st_reg.port[p].ctl.upper_lane_enable_n,
                                          st_reg.port[p].ctl.lower_lane_enable_n};
                st_next.port[p].q     = mem[iaddr[p]];
            end else begin
                st_next.port[p].drive = 2'b00;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int p = 0; p < SPDP_PORTS; p++) begin
                st_reg.port[p].ctl     <= SPDP_CTL_RST;
                st_reg.port[p].wdata   <= SPDP_DATA_RST;
                st_reg.port[p].counter <= SPDP_ADDR_RST;
                st_reg.port[p].awake   <= 1'b0;
                st_reg.port[p].q       <= SPDP_DATA_RST;
                st_reg.port[p].drive   <= 2'b00;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************
    // Array write
    // ****************************************************
    // Write lands one cycle after capture, standing in for the self-timed pulse.
    // Same-address writes from both ports: the right port wins, collisions unmodelled.
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < SPDP_PORTS; p++) begin
            for (int l = 0; l < SPDP_LANES; l++) begin
                if (wr_lane[p][l]) begin
                    mem[iaddr[p]][l*SPDP_LANE_W +: SPDP_LANE_W] <=
                        st_reg.port[p].wdata[l*SPDP_LANE_W +: SPDP_LANE_W];
                end
            end
        end
    end

endmodule : spdp_port_dev

`default_nettype wire

// ### logic/spdp_port_mst.sv
`timescale 1ns/10ps
`default_nettype none

module spdp_port_mst
    import spdp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // User request
    input  wire logic        req_i,
    input  wire logic        req_write_i,
    input  wire logic [1:0]  req_op_i,
    input  wire logic        req_clear_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [17:0] req_data_i,
    input  wire logic [1:0]  req_lane_n_i,
    input  wire logic        standby_i,
    output logic             ready_o,
    // User response
    output logic             rsp_valid_o,
    output logic [17:0]      rsp_data_o,
    // Memory port
    spdp_if.mst              mem_port
);

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        spdp_ctl_t   ctl;
        logic [17:0] data;
        logic [1:0]  data_oe;
        logic [2:0]  rd_pipe;
        logic        rsp_valid;
        logic [17:0] rsp_data;
        logic [1:0]  wake;
        logic        prev_read;
        logic        prev_gap;
        logic        rewrite;
        logic [15:0] rw_addr;
        logic [17:0] rw_data;
        logic [1:0]  rw_lane_n;
    } spdp_mst_state_t;

    spdp_mst_state_t st_reg;
    spdp_mst_state_t st_next;
    logic            take;
    logic            active;

    assign active  = ~standby_i;
    // Writes wait out a read still on its way back, avoiding bus contention
    assign ready_o = active && (st_reg.wake == SPDP_WAKE_CYCLES) && !st_reg.rewrite
                   && !(req_write_i && st_reg.rd_pipe[1]);
    assign take    = req_i && ready_o;

    assign mem_port.ctl         = st_reg.ctl;
    assign mem_port.mst_data    = st_reg.data;
    assign mem_port.mst_data_oe = st_reg.data_oe;
    assign rsp_valid_o          = st_reg.rsp_valid;
    assign rsp_data_o           = st_reg.rsp_data;

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        st_next           = st_reg;
        st_next.ctl       = SPDP_CTL_RST;
        st_next.data_oe   = 2'b00;
        st_next.rd_pipe   = {st_reg.rd_pipe[1:0], 1'b0};
        st_next.rsp_valid = st_reg.rd_pipe[2];
        st_next.rsp_data  = mem_port.bus;
        // Chip enables of opposite polarity from one decoded level
        st_next.ctl.first_select_n = ~active;
        st_next.ctl.second_select  = active;
        st_next.ctl.out_enable_n   = 1'b0;
        st_next.wake = !active ? 2'b00
                     : (st_reg.wake == SPDP_WAKE_CYCLES) ? st_reg.wake
                     : 2'(st_reg.wake + 2'h1);
        st_next.prev_read = 1'b0;
        // Gap outlives refused cycles, so a write that waits out the read still counts
        st_next.prev_gap  = (st_reg.prev_gap || st_reg.prev_read) && !take;
        if (st_reg.rewrite) begin
            // Repeat the write that followed read and idle_cycle
            st_next.ctl.read                = 1'b0;
            st_next.ctl.addr                = st_reg.rw_addr;
            st_next.ctl.upper_lane_enable_n = st_reg.rw_lane_n[1];
            st_next.ctl.lower_lane_enable_n = st_reg.rw_lane_n[0];
            st_next.ctl.out_enable_n        = 1'b1;
            st_next.data                    = st_reg.rw_data;
            st_next.data_oe                 = ~st_reg.rw_lane_n;
            st_next.rewrite                 = 1'b0;
        end else if (take) begin
            st_next.ctl.addr                  = req_addr_i;
            st_next.ctl.read                  = ~req_write_i;
            st_next.ctl.count_clear_n         = ~req_clear_i;
            st_next.ctl.address_load_strobe_n = (req_op_i != SPDP_OP_LOAD);
            st_next.ctl.count_advance_n       = (req_op_i != SPDP_OP_ADVANCE);
            st_next.ctl.upper_lane_enable_n   = req_lane_n_i[1];
            st_next.ctl.lower_lane_enable_n   = req_lane_n_i[0];
            if (req_write_i) begin
                st_next.ctl.out_enable_n = 1'b1;
                st_next.data             = req_data_i;
                st_next.data_oe          = ~req_lane_n_i;
                // Rewrite only a plain loaded write, whose address is known
                st_next.rewrite   = st_reg.prev_gap && !st_reg.prev_read
                                  && (req_op_i == SPDP_OP_LOAD) && !req_clear_i;
                st_next.rw_addr   = req_addr_i;
                st_next.rw_data   = req_data_i;
                st_next.rw_lane_n = req_lane_n_i;
            end else begin
                st_next.rd_pipe[0] = 1'b1;
                st_next.prev_read  = 1'b1;
            end
        end
        // Idle cycles present a read with both lanes off that loads address 0000 into the counter
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg.ctl       <= SPDP_CTL_RST;
            st_reg.data      <= SPDP_DATA_RST;
            st_reg.data_oe   <= 2'b00;
            st_reg.rd_pipe   <= 3'b000;
            st_reg.rsp_valid <= 1'b0;
            st_reg.rsp_data  <= SPDP_DATA_RST;
            st_reg.wake      <= 2'b00;
            st_reg.prev_read <= 1'b0;
            st_reg.prev_gap  <= 1'b0;
            st_reg.rewrite   <= 1'b0;
            st_reg.rw_addr   <= SPDP_ADDR_RST;
            st_reg.rw_data   <= SPDP_DATA_RST;
            st_reg.rw_lane_n <= 2'b11;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : spdp_port_mst

`default_nettype wire

// ### sim/spdp_checker.sv
`timescale 1ns/10ps
`default_nettype none

module spdp_checker
    import spdp_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    // Port wires
    input wire spdp_ctl_t   ctl,
    input wire logic [17:0] dev_data,
    input wire logic [1:0]  dev_data_oe,
    input wire logic [1:0]  mst_data_oe
);
    logic sel;
    logic rd;
    logic hold_rd;
    assign sel     = !ctl.first_select_n && ctl.second_select;
    assign rd      = sel && ctl.read && !ctl.lower_lane_enable_n && !ctl.upper_lane_enable_n;
    assign hold_rd = rd && ctl.address_load_strobe_n && ctl.count_advance_n && ctl.count_clear_n;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // ****
    // Drive is only a late answer to a selected read
    // ****
    lower_drive_cause_a: assert property (dev_data_oe[0] |-> $past(ctl.read, 2) && $past(sel, 2)
        && $past(sel, 3) && !$past(ctl.lower_lane_enable_n, 2)) else $error("lower lane driven without read");
    upper_drive_cause_a: assert property (dev_data_oe[1] |-> $past(ctl.read, 2) && $past(sel, 2)
        && $past(sel, 3) && !$past(ctl.upper_lane_enable_n, 2)) else $error("upper lane driven without read");
    read_drive_due_a: assert property ($past(ctl.read, 2) && $past(sel, 2) && $past(sel, 3)
        && !$past(ctl.lower_lane_enable_n, 2) && !ctl.out_enable_n |-> dev_data_oe[0])
        else $error("read answer not driven");
    oe_async_float_a: assert property (ctl.out_enable_n |-> dev_data_oe == 2'h0)
        else $error("driven while output enable high");
    deselect_float_a: assert property (!$past(sel, 2) || !$past(sel, 3) |-> dev_data_oe == 2'h0)
        else $error("driven before two selected cycles");
    no_contention_a: assert property ((dev_data_oe & mst_data_oe) == 2'h0)
        else $error("both ends drive one lane");
    mst_write_only_a: assert property (mst_data_oe != 2'h0 |-> !ctl.read && ctl.out_enable_n && sel)
        else $error("master drives data outside a write");
    hold_steady_a: assert property ($past(hold_rd, 2) && $past(rd, 3) && $past(sel, 4) |-> $stable(dev_data))
        else $error("held read data changed");

    // Main scenarios reached
    full_read_c: cover property (dev_data_oe == 2'h3);
    full_write_c: cover property (mst_data_oe == 2'h3);
    hold_pair_c: cover property (hold_rd ##1 hold_rd);
    rewrite_pair_c: cover property ((mst_data_oe != 2'h0) ##1 (mst_data_oe != 2'h0 && $stable(ctl.addr)));
endmodule : spdp_checker

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    import spdp_pkg::*;

    logic        clk_i;
    logic        arst_n_i;
    logic [40:0] rq [2];
    logic [1:0]  sb;
    wire  [1:0]  rdy;
    wire  [1:0]  rv;
    wire  [17:0] rdat [2];
    logic [17:0] rsp_q [2][$];
    int          err_total;
    int          cmp_count;
    logic [15:0] addr_t [4] = '{16'h0000, 16'hFFFF, 16'h1234, 16'h8001};
    logic [1:0]  op_t [5]   = '{SPDP_OP_LOAD, SPDP_OP_ADVANCE, SPDP_OP_HOLD, SPDP_OP_HOLD, SPDP_OP_LOAD};
    logic [15:0] cnt_t [5]  = '{16'h0100, 16'h0101, 16'h0101, 16'h0101, 16'h0000};

    spdp_if ifs [2] ();

    spdp_port_dev spdp_port_dev_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .port_a(ifs[0]), .port_b(ifs[1]));

    for (genvar g = 0; g < 2; g++) begin : gen_mst
        spdp_port_mst spdp_port_mst_i (
            .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(rq[g][40]), .req_write_i(rq[g][39]),
            .req_op_i(rq[g][38:37]), .req_clear_i(rq[g][36]), .req_addr_i(rq[g][35:20]),
            .req_data_i(rq[g][19:2]), .req_lane_n_i(rq[g][1:0]), .standby_i(sb[g]),
            .ready_o(rdy[g]), .rsp_valid_o(rv[g]), .rsp_data_o(rdat[g]), .mem_port(ifs[g]));
    end

    spdp_checker spdp_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .ctl(ifs[0].ctl),
        .dev_data(ifs[0].dev_data), .dev_data_oe(ifs[0].dev_data_oe), .mst_data_oe(ifs[0].mst_data_oe));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ****
    // Helpers
    // ****
    always @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rv[i] === 1'b1) begin
                rsp_q[i].push_back(rdat[i]);
            end
        end
    end

    function automatic logic [17:0] pat(input logic [15:0] a);
        return {~a[8:0], a[15:7]};
    endfunction

    task automatic cmp_data(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_data({17'h0_0000, got}, {17'h0_0000, exp});
    endtask

    // Request stays up at exit so back-to-back calls never drive twice in one step
    task automatic issue(input int p, input logic w, input logic [1:0] o, input logic c,
                         input logic [15:0] a, input logic [17:0] d, input logic [1:0] l);
        int n;
        n = 0;
        rq[p] <= {1'b1, w, o, c, a, d, l};
        do begin
            @(negedge clk_i);
            n++;
        end while (rdy[p] !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_total++;
        end
        @(posedge clk_i);
    endtask

    task automatic idle(input int p, input int k);
        rq[p][40] <= 1'b0;
        repeat (k) @(posedge clk_i);
    endtask

    task automatic take(input int p, input logic [17:0] e);
        int n;
        n = 0;
        while (rsp_q[p].size() == 0 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (rsp_q[p].size() == 0) begin
            err_total++;
        end else begin
            cmp_data(rsp_q[p].pop_front(), e);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_i);
        err_total++;
        summarize();
    end

    // ****
    // Stimulus
    // ****
    initial begin
        arst_n_i = 1'b0;
        rq[0] = '0;
        rq[1] = '0;
        sb = 2'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk_i);
        cmp_bit(ifs[0].ctl.first_select_n, 1'b1);
        cmp_bit(ifs[0].ctl.second_select, 1'b0);
        cmp_data({16'h0000, ifs[0].dev_data_oe}, 18'h0_0000);
        arst_n_i <= 1'b1;
        $display("test reset_levels done");
        for (int i = 0; i < 4; i++) begin
            issue(0, 1'b1, SPDP_OP_LOAD, 1'b0, addr_t[i], pat(addr_t[i]), 2'h0);
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 3; i >= 0; i--) begin
                issue(p, 1'b0, SPDP_OP_LOAD, 1'b0, addr_t[i], 18'h0_0000, 2'h0);
            end
            idle(p, 1);
            for (int i = 3; i >= 0; i--) begin
                take(p, pat(addr_t[i]));
            end
        end
        $display("test load_both_ports done");
        issue(0, 1'b1, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h3_FFFF, 2'h0);
        issue(0, 1'b1, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0055, 2'h2);
        issue(0, 1'b0, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0000, 2'h0);
        issue(0, 1'b0, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0000, 2'h1);
        issue(0, 1'b0, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0000, 2'h2);
        idle(0, 1);
        take(0, 18'h3_FE55);
        take(0, 18'h3_FE00);
        take(0, 18'h0_0055);
        $display("test byte_lanes done");
        issue(0, 1'b1, SPDP_OP_LOAD, 1'b0, 16'h0100, pat(16'h0100), 2'h0);
        issue(0, 1'b1, SPDP_OP_ADVANCE, 1'b0, 16'h0ABC, pat(16'h0101), 2'h0);
        for (int i = 0; i < 5; i++) begin
            issue(0, 1'b0, op_t[i], i == 4, (i == 0 || i == 4) ? 16'h0100 : 16'h0ABC, 18'h0_0000, 2'h0);
        end
        idle(0, 1);
        for (int i = 0; i < 5; i++) begin
            take(0, pat(cnt_t[i]));
        end
        $display("test address_counter done");
        issue(0, 1'b0, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0000, 2'h0);
        idle(0, 1);
        issue(0, 1'b1, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h2_AAAA, 2'h0);
        @(negedge clk_i);
        cmp_bit(rdy[0], 1'b0);
        @(posedge clk_i);
        issue(0, 1'b0, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0000, 2'h0);
        idle(0, 1);
        take(0, 18'h3_FE55);
        take(0, 18'h2_AAAA);
        $display("test read_idle_write done");
        sb[0] <= 1'b1;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        cmp_bit(rdy[0], 1'b0);
        cmp_bit(ifs[0].ctl.first_select_n, 1'b1);
        cmp_bit(ifs[0].ctl.second_select, 1'b0);
        @(posedge clk_i);
        sb[0] <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        cmp_bit(rdy[0], 1'b0);
        @(posedge clk_i);
        issue(0, 1'b0, SPDP_OP_LOAD, 1'b0, 16'h0040, 18'h0_0000, 2'h0);
        idle(0, 1);
        take(0, 18'h2_AAAA);
        $display("test standby_wake done");
        summarize();
    end
endmodule : tb

`default_nettype wire
